// >>> common/adcseq_pkg.sv
// Shared constants for the ADC conversion sequencer.
package adcseq_pkg;
    localparam int NUM_CH = 21;
    localparam int NUM_BIP = 16;
    localparam int RES_W = 12;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int CH_W = 5;
    localparam int CNT_W = 14;
    //////////////////////////////////////////////////////////////////////////
    // Register offsets on the register port.
    localparam logic [7:0] OFF_CFG = 8'h00;
    localparam logic [7:0] OFF_MUX_LO = 8'h01;
    localparam logic [7:0] OFF_MUX_HI = 8'h02;
    localparam logic [7:0] OFF_CMD = 8'h03;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_DATA0 = 8'h20;
    // Field positions.
    localparam int CFG_REF_EN = 0;
    localparam int CFG_BUF_EN = 1;
    localparam int CFG_PWR_EN = 2;
    localparam int CFG_MODE = 3;
    localparam int CFG_RATE_LSB = 4;
    localparam int CFG_W = 6;
    localparam int MUX_LO_W = 16;
    localparam int CMD_START = 0;
    localparam int CMD_SRST = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_ACTIVE = 1;
    localparam int STAT_CH_LSB = 8;
    // Reset values and codes.
    localparam logic [5:0] CFG_RST = 6'h00;
    localparam logic [20:0] MUX_RST = 21'h000000;
    localparam logic [11:0] DATA_RST = 12'h000;
    localparam logic [1:0] RATE_FAST = 2'h0;
    localparam logic [1:0] RATE_MID = 2'h1;
    localparam logic [1:0] RATE_SLOW = 2'h3;
    //////////////////////////////////////////////////////////////////////////
    // Timing: per-channel slot from single-channel throughput, rounded up.
    localparam int CLK_HZ = 200_000_000;
    localparam int RATE_87K_SPS = 87000;
    localparam int RATE_43K5_SPS = 43500;
    localparam int RATE_29K_SPS = 29000;
    localparam int RATE_14K5_SPS = 14500;
    localparam logic [13:0] SLOT_87K_CYC =
        14'((CLK_HZ + RATE_87K_SPS - 1) / RATE_87K_SPS);
    localparam logic [13:0] SLOT_43K5_CYC =
        14'((CLK_HZ + RATE_43K5_SPS - 1) / RATE_43K5_SPS);
    localparam logic [13:0] SLOT_29K_CYC =
        14'((CLK_HZ + RATE_29K_SPS - 1) / RATE_29K_SPS);
    localparam logic [13:0] SLOT_14K5_CYC =
        14'((CLK_HZ + RATE_14K5_SPS - 1) / RATE_14K5_SPS);
endpackage : adcseq_pkg

// >>> logic/adcseq_top.sv
// ADC conversion sequencer with register port and result store.
`timescale 1ns/1ps
// Function
// RQ1: Conversions run only with reference, reference buffer and power enabled.
// RQ2: Twenty-one channels, sixteen bipolar and five low-voltage, 12-bit results.
// RQ3: Only channels whose mask bit is set take part in a sweep.
// RQ4: Direct mode converts each enabled channel once, in order, then stops.
// RQ5: Host issues a fresh start before each read wanting new results.
// RQ6: Auto mode keeps sweeping the enabled channels without further commands.
// RQ7: Auto mode wraps from the last enabled channel to the first.
// RQ8: A start command during auto sweeping halts it.
// RQ9: Two-bit rate code sets slot time per bipolar and low-voltage channel.
// RQ10: Software reset returns every register and the sequencer to defaults.
// RQ11: Each finished conversion is stored in that channel's data register.
module adcseq_top
    import adcseq_pkg::*;
#(
    parameter logic [13:0] P_SLOT_43K5 = SLOT_43K5_CYC,
    parameter logic [13:0] P_SLOT_29K = SLOT_29K_CYC,
    parameter logic [13:0] P_SLOT_14K5 = SLOT_14K5_CYC
) (
    // Clock, reset and freeze
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    input wire logic CE_I,
    // Register port
    input wire logic [ADDR_W-1:0] REG_ADDR_I,
    input wire logic [DATA_W-1:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [DATA_W-1:0] REG_RDATA_O,
    // Converter core
    output logic ADC_ACTIVE_O,
    output logic ADC_START_O,
    output logic [CH_W-1:0] ADC_CHAN_O,
    input wire logic ADC_DONE_I,
    input wire logic [RES_W-1:0] ADC_DATA_I,
    // Status
    output logic SEQ_BUSY_O
);
    typedef enum logic [0:0] {S_IDLE, S_WAIT} adcseq_state_t;

    logic [CFG_W-1:0] cfg;
    logic [CFG_W-1:0] next_cfg;
    logic [NUM_CH-1:0] mask;
    logic [NUM_CH-1:0] next_mask;
    logic [RES_W-1:0] data_mem [NUM_CH];
    logic [RES_W-1:0] next_mem [NUM_CH];
    logic [DATA_W-1:0] next_rdata;
    adcseq_state_t seq_state;
    adcseq_state_t next_state;
    logic [CH_W-1:0] next_chan;
    logic [CNT_W-1:0] slot_cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [CNT_W-1:0] slot_hold;
    logic [CNT_W-1:0] next_hold;
    logic [CNT_W-1:0] gap;
    logic [CNT_W-1:0] next_gap;
    logic got;
    logic next_got;
    logic next_start;
    logic next_active;
    logic next_busy;
    logic wr_cmd;
    logic go_cmd;
    logic soft_cmd;
    logic capture;
    logic adv;
    logic launch;
    logic [CH_W-1:0] launch_ch;
    logic [5:0] first_scan;
    logic [5:0] next_scan;
    logic first_hit;
    logic last_ch;
    logic [CH_W-1:0] rd_idx;
    logic [CH_W-1:0] chan_inc;

    // Lowest set mask bit at or above the given channel, with a hit flag.
    function automatic logic [5:0] scan_from(input logic [NUM_CH-1:0] m,
                                             input logic [CH_W-1:0] from);
        logic [5:0] r;
        r = 6'h00;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (m[i] && (i >= int'(from))) begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction : scan_from

    // Slot length in clock cycles for one channel at the given rate code.
    function automatic logic [CNT_W-1:0] slot_len(input logic [CH_W-1:0] ch,
                                                  input logic [1:0] rate);
        logic [CNT_W-1:0] r;
        r = P_SLOT_29K;
        if (rate == RATE_SLOW) begin
            r = P_SLOT_14K5; // [RQ9]
        end else if (ch >= 5'(NUM_BIP)) begin
            case (rate) // [RQ9]
                RATE_FAST: r = SLOT_87K_CYC;
                RATE_MID: r = P_SLOT_43K5;
                default: r = P_SLOT_29K;
            endcase
        end
        return r;
    endfunction : slot_len

    ////////////////////////////////////////////////////////////////////////////
    // Decode and channel search.
    assign wr_cmd = REG_WR_I && (REG_ADDR_I == OFF_CMD);
    assign go_cmd = wr_cmd && REG_WDATA_I[CMD_START];
    assign soft_cmd = wr_cmd && REG_WDATA_I[CMD_SRST];
    assign capture = (seq_state == S_WAIT) && ADC_DONE_I && !got;
    assign adv = (seq_state == S_WAIT) && (slot_cnt == '0) && got;
    assign chan_inc = 5'(ADC_CHAN_O + 5'h01);
    assign first_scan = scan_from(mask, 5'h00); // [RQ3]
    assign next_scan = scan_from(mask, chan_inc); // [RQ3]
    assign first_hit = first_scan[5];
    assign last_ch = !next_scan[5];
    assign rd_idx = 5'(REG_ADDR_I - OFF_DATA0);

    ////////////////////////////////////////////////////////////////////////////
    // Register file.
    always_comb begin
        next_cfg = cfg;
        next_mask = mask;
        next_mem = data_mem;
        next_rdata = '0;
        if (REG_WR_I) begin
            case (REG_ADDR_I)
                OFF_CFG: next_cfg = REG_WDATA_I[CFG_W-1:0];
                OFF_MUX_LO: next_mask[MUX_LO_W-1:0] = REG_WDATA_I;
                OFF_MUX_HI: begin
                    next_mask[NUM_CH-1:MUX_LO_W] =
                        REG_WDATA_I[NUM_CH-MUX_LO_W-1:0];
                end
                default: ;
            endcase
        end
        if (capture) begin
            next_mem[ADC_CHAN_O] = ADC_DATA_I; // [RQ11]
        end
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                OFF_CFG: next_rdata = 16'(cfg);
                OFF_MUX_LO: next_rdata = mask[MUX_LO_W-1:0];
                OFF_MUX_HI: next_rdata = 16'(mask[NUM_CH-1:MUX_LO_W]);
                OFF_STAT: begin
                    next_rdata[STAT_BUSY] = SEQ_BUSY_O;
                    next_rdata[STAT_ACTIVE] = ADC_ACTIVE_O;
                    next_rdata[STAT_CH_LSB +: CH_W] = ADC_CHAN_O;
                end
                default: begin
                    // Bound the full address so the data window never aliases.
                    if (REG_ADDR_I >= OFF_DATA0 &&
                        REG_ADDR_I < 8'(OFF_DATA0 + NUM_CH)) begin
                        next_rdata = 16'(data_mem[rd_idx]); // [RQ2]
                    end
                end
            endcase
        end
        if (soft_cmd) begin
            next_cfg = CFG_RST; // [RQ10]
            next_mask = MUX_RST;
            for (int i = 0; i < NUM_CH; i++) begin
                next_mem[i] = DATA_RST;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            cfg <= CFG_RST;
            mask <= MUX_RST;
            REG_RDATA_O <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                data_mem[i] <= DATA_RST;
            end
        end else if (CE_I) begin
            cfg <= next_cfg;
            mask <= next_mask;
            REG_RDATA_O <= next_rdata;
            data_mem <= next_mem;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sweep sequencer. A direct-mode start while busy is ignored; only an
    // auto sweep can be halted, since a direct sweep ends by itself.
    always_comb begin
        next_state = seq_state;
        next_chan = ADC_CHAN_O;
        next_cnt = slot_cnt;
        next_hold = slot_hold;
        next_got = got || capture;
        next_start = 1'b0;
        next_active = &cfg[CFG_PWR_EN:CFG_REF_EN]; // [RQ1]
        next_gap = ADC_START_O ? 14'h0001 :
                   ((gap == '1) ? gap : 14'(gap + 14'h0001));
        launch = 1'b0;
        launch_ch = first_scan[CH_W-1:0];
        if (seq_state == S_WAIT && slot_cnt != '0) begin
            next_cnt = 14'(slot_cnt - 14'h0001);
        end
        if (soft_cmd) begin
            next_state = S_IDLE; // [RQ10]
            next_chan = '0;
            next_cnt = '0;
            next_got = 1'b0;
            next_active = 1'b0;
        end else if (!ADC_ACTIVE_O) begin
            next_state = S_IDLE; // [RQ1]
        end else if (go_cmd && seq_state == S_WAIT && cfg[CFG_MODE]) begin
            next_state = S_IDLE; // [RQ8]
        end else if (go_cmd && seq_state == S_IDLE) begin
            launch = first_hit; // [RQ4]
        end else if (adv) begin
            if (!last_ch) begin
                launch = 1'b1; // [RQ4]
                launch_ch = next_scan[CH_W-1:0];
            end else if (cfg[CFG_MODE] && first_hit) begin
                launch = 1'b1; // [RQ6] [RQ7]
            end else begin
                next_state = S_IDLE; // [RQ4]
            end
        end
        if (launch) begin
            next_state = S_WAIT;
            next_chan = launch_ch;
            next_cnt = 14'(slot_len(launch_ch,
                cfg[CFG_RATE_LSB +: 2]) - 14'h0001); // [RQ9]
            next_hold = next_cnt;
            next_got = 1'b0;
            next_start = 1'b1;
        end
        next_busy = (next_state == S_WAIT);
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            seq_state <= S_IDLE;
            ADC_CHAN_O <= '0;
            slot_cnt <= '0;
            slot_hold <= '0;
            gap <= '0;
            got <= 1'b0;
            ADC_START_O <= 1'b0;
            ADC_ACTIVE_O <= 1'b0;
            SEQ_BUSY_O <= 1'b0;
        end else if (CE_I) begin
            seq_state <= next_state;
            ADC_CHAN_O <= next_chan;
            slot_cnt <= next_cnt;
            slot_hold <= next_hold;
            gap <= next_gap;
            got <= next_got;
            ADC_START_O <= next_start;
            ADC_ACTIVE_O <= next_active;
            SEQ_BUSY_O <= next_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (SYS_RST_I);

    sequence s_go;
        CE_I && go_cmd && !soft_cmd && seq_state == S_IDLE &&
        ADC_ACTIVE_O && first_hit;
    endsequence
    sequence s_wrap;
        CE_I && adv && cfg[CFG_MODE] && last_ch && first_hit &&
        ADC_ACTIVE_O && !go_cmd && !soft_cmd;
    endsequence

    a_active_gate: assert property ( // [RQ1]
        $past(CE_I) && !$past(soft_cmd) |->
        ADC_ACTIVE_O == $past(&cfg[CFG_PWR_EN:CFG_REF_EN]))
        else $error("active flag does not follow the three enables");
    a_start_active: assert property ( // [RQ1]
        $rose(ADC_START_O) |-> $past(ADC_ACTIVE_O))
        else $error("conversion started while converter inactive");
    a_chan_range: assert property ( // [RQ2]
        ADC_CHAN_O < 5'(NUM_CH))
        else $error("channel index out of range");
    a_chan_enabled: assert property ( // [RQ3]
        $rose(ADC_START_O) |->
        (($past(mask) >> ADC_CHAN_O) & 21'h000001) != 21'h000000)
        else $error("conversion started on a masked channel");
    a_sweep_start: assert property ( // [RQ4]
        s_go |=> ADC_START_O && ADC_CHAN_O == $past(first_scan[CH_W-1:0]))
        else $error("start command did not begin at first channel");
    a_sweep_order: assert property ( // [RQ4]
        CE_I && adv && !last_ch && ADC_ACTIVE_O && !soft_cmd &&
        !(go_cmd && cfg[CFG_MODE]) |=>
        ADC_START_O && ADC_CHAN_O > $past(ADC_CHAN_O))
        else $error("sweep did not advance to a higher channel");
    a_direct_stop: assert property ( // [RQ4]
        CE_I && adv && last_ch && !cfg[CFG_MODE] |=>
        seq_state == S_IDLE && !ADC_START_O)
        else $error("direct sweep did not stop after last channel");
    a_auto_wrap: assert property ( // [RQ6] [RQ7]
        s_wrap |=> ADC_START_O && SEQ_BUSY_O &&
        ADC_CHAN_O == $past(first_scan[CH_W-1:0]))
        else $error("auto sweep did not wrap to first channel");
    a_auto_halt: assert property ( // [RQ8]
        CE_I && go_cmd && cfg[CFG_MODE] && seq_state == S_WAIT |=>
        seq_state == S_IDLE && !SEQ_BUSY_O)
        else $error("start command did not halt auto sweep");
    a_slot_time: assert property ( // [RQ9]
        CE_I && adv |-> gap >= slot_hold)
        else $error("channel slot ended early");
    a_soft_reset: assert property ( // [RQ10]
        CE_I && soft_cmd |=> seq_state == S_IDLE && cfg == CFG_RST &&
        mask == MUX_RST && !ADC_START_O)
        else $error("software reset did not restore defaults");
    a_result_store: assert property ( // [RQ11]
        capture && CE_I && !soft_cmd |=>
        data_mem[$past(ADC_CHAN_O)] == $past(ADC_DATA_I))
        else $error("conversion result not stored");
endmodule : adcseq_top

// >>> dv/adcseq_top_tb.sv
// Self-checking testbench for the ADC conversion sequencer.
`timescale 1ns/1ps
module adcseq_top_tb;
    import adcseq_pkg::*;
    // Short slots keep the run brief; the 87 kSPS slot is fixed.
    localparam logic [13:0] S43 = 14'h0028;
    localparam logic [13:0] S29 = 14'h003C;
    localparam logic [13:0] S14 = 14'h0064;
    localparam logic [13:0] S87 = 14'h08FB;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wstb = 1'b0;
    logic rstb = 1'b0;
    logic done = 1'b0;
    logic [RES_W-1:0] res = '0;
    logic [DATA_W-1:0] rdata;
    logic act;
    logic start;
    logic busy;
    logic [CH_W-1:0] chan;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    adcseq_top #(.P_SLOT_43K5(S43), .P_SLOT_29K(S29), .P_SLOT_14K5(S14))
        dut_u (.CLK_SYS_I(clk), .SYS_RST_I(rst), .CE_I(ce),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wstb),
        .REG_RD_I(rstb), .REG_RDATA_O(rdata), .ADC_ACTIVE_O(act),
        .ADC_START_O(start), .ADC_CHAN_O(chan), .ADC_DONE_I(done),
        .ADC_DATA_I(res), .SEQ_BUSY_O(busy));
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_gap(input int got, input int exp);
        compares++;
        if (got != exp) begin
            n_fail++;
            $display("mismatch at %0t: gap %h exp %h", $time, got, exp);
        end
    endtask : chk_gap
    task automatic settle();
        @(posedge clk);
        #1;
    endtask : settle
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wstb <= 1'b1;
        @(posedge clk);
        wstb <= 1'b0;
    endtask : reg_wr
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clk);
        rstb <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rd_chk
    // Waits for a launch, checks its channel and answers with a result.
    // The start pulse stands one cycle, so the launch cycle is looked at too.
    task automatic conv(input logic [4:0] ch, output int t);
        #1;
        repeat (3000) begin
            if (start === 1'b1) break;
            settle();
        end
        if (start !== 1'b1) begin
            n_fail++;
            conclude();
        end
        t = cyc;
        chk(16'(chan), 16'(ch));
        @(posedge clk);
        done <= 1'b1;
        res <= 12'hC30 + 12'(ch);
        @(posedge clk);
        done <= 1'b0;
    endtask : conv
    task automatic quiet(input int n);
        int hits;
        hits = 0;
        repeat (n) begin
            settle();
            if (start === 1'b1) hits++;
        end
        chk(16'(hits), 16'h0000);
    endtask : quiet
    ////////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        rd_chk(OFF_CFG, 16'h0000);
        rd_chk(OFF_MUX_LO, 16'h0000);
        rd_chk(OFF_MUX_HI, 16'h0000);
        rd_chk(OFF_STAT, 16'h0000);
        rd_chk(OFF_DATA0 + 8'h14, 16'h0000);
        rd_chk(8'h1F, 16'h0000);
        $display("test defaults finished");
    endtask : t_defaults
    // Every partial enable set must keep the converter idle.
    task automatic t_gate();
        reg_wr(OFF_MUX_LO, 16'h0001);
        for (int c = 0; c < 7; c++) begin
            reg_wr(OFF_CFG, 16'(c));
            reg_wr(OFF_CMD, 16'h0001);
            settle();
            chk(16'(act), 16'h0000);
            quiet(8);
        end
        reg_wr(OFF_CFG, 16'h0007);
        settle();
        chk(16'(act), 16'h0001);
        rd_chk(OFF_STAT, 16'h0002);
        // With the clock enable low a write must be lost and state kept.
        @(posedge clk);
        ce <= 1'b0;
        reg_wr(OFF_CFG, 16'h0000);
        ce <= 1'b1;
        settle();
        chk(16'(act), 16'h0001);
        rd_chk(OFF_CFG, 16'h0007);
        $display("test gating finished");
    endtask : t_gate
    task automatic t_direct();
        int t;
        reg_wr(OFF_CFG, 16'h0027);
        reg_wr(OFF_MUX_LO, 16'h0022);
        reg_wr(OFF_MUX_HI, 16'h0002);
        reg_wr(OFF_CMD, 16'h0001);
        conv(5'h01, t);
        // A second start inside a direct sweep must not add a sweep.
        reg_wr(OFF_CMD, 16'h0001);
        conv(5'h05, t);
        conv(5'h11, t);
        quiet(70);
        chk(16'(busy), 16'h0000);
        rd_chk(OFF_DATA0 + 8'h01, 16'h0C31);
        rd_chk(OFF_DATA0 + 8'h05, 16'h0C35);
        rd_chk(OFF_DATA0 + 8'h11, 16'h0C41);
        rd_chk(OFF_DATA0, 16'h0000);
        rd_chk(8'h41, 16'h0000);
        $display("test direct finished");
    endtask : t_direct
    task automatic t_auto(input logic [1:0] r);
        int t0, t1, t2, t3;
        logic [13:0] bs, ls;
        bs = (r == 2'h3) ? S14 : S29;
        ls = (r == 2'h0) ? S87 : (r == 2'h1) ? S43 : bs;
        reg_wr(OFF_CFG, {10'h000, r, 4'hF});
        reg_wr(OFF_MUX_LO, 16'h0001);
        reg_wr(OFF_MUX_HI, 16'h0001);
        reg_wr(OFF_CMD, 16'h0001);
        conv(5'h00, t0);
        conv(5'h10, t1);
        conv(5'h00, t2);
        conv(5'h10, t3);
        chk_gap(t1 - t0, int'(bs));
        chk_gap(t2 - t1, int'(ls));
        chk_gap(t3 - t2, int'(bs));
        reg_wr(OFF_CMD, 16'h0001);
        quiet(int'(ls) + 10);
        chk(16'(busy), 16'h0000);
        $display("test auto rate %0d finished", r);
    endtask : t_auto
    // Soft reset is issued mid-sweep, together with a start, to show it wins.
    task automatic t_srst();
        int t;
        reg_wr(OFF_CMD, 16'h0001);
        conv(5'h00, t);
        reg_wr(OFF_CMD, 16'h0003);
        settle();
        chk(16'(act), 16'h0000);
        chk(16'(busy), 16'h0000);
        rd_chk(OFF_CFG, 16'h0000);
        rd_chk(OFF_MUX_LO, 16'h0000);
        rd_chk(OFF_MUX_HI, 16'h0000);
        rd_chk(OFF_DATA0 + 8'h01, 16'h0000);
        quiet(100);
        $display("test soft reset finished");
    endtask : t_srst
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_defaults();
        t_gate();
        t_direct();
        for (int r = 0; r < 4; r++) begin
            t_auto(2'(r));
        end
        t_srst();
        conclude();
    end
endmodule : adcseq_top_tb
